// file: hw/pll_latch_pkg.sv
// shared constants for the serial divider latch bank
package pll_latch_pkg;
    localparam int WORD_W        = 24;
    localparam int A_W           = 5;
    localparam int B_W           = 13;
    localparam int R_W           = 14;
    // latch select codes (bit1, bit0)
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_REF     = 2'h1;
    localparam logic [1:0] SEL_FEEDBK  = 2'h2;
    // control latch fields
    localparam int CTL_CORE_POWER_LSB = 2;
    localparam int CTL_COUNTER_RESET  = 4;
    localparam int CTL_OUTSEL_LSB     = 5;
    localparam int CTL_PHASE_POL      = 8;
    localparam int CTL_PUMP_GAIN      = 10;
    // feedback latch fields
    localparam int N_A_LSB            = 2;
    localparam int N_B_LSB            = 8;
    localparam int N_PUMP_GAIN        = 21;
    localparam int N_HALVING          = 22;
    localparam int N_PRESC_SRC        = 23;
    // reference latch fields
    localparam int R_COUNT_LSB        = 2;
    localparam int R_BACKLASH_LSB     = 16;
    localparam int R_LOCK_PREC        = 18;
    localparam int R_TEST             = 19;
    localparam int R_BAND_DIV_LSB     = 20;
    // reset values
    localparam logic [WORD_W-1:0] CTL_RESET = 24'h000000;
    localparam logic [WORD_W-1:0] N_RESET   = 24'h000000;
    localparam logic [WORD_W-1:0] R_RESET   = 24'h000000;
    // lock detect counts
    localparam logic [2:0] LOCK_CNT_FINE   = 3'h5;
    localparam logic [2:0] LOCK_CNT_COARSE = 3'h3;
endpackage

// file: hw/pll_divider_latches.sv
// serial latch bank and divider configuration of the synthesizer
`timescale 1ns/100ps
module pll_divider_latches
    import pll_latch_pkg::*;
#(
    parameter int PRESCALER = 8    // dual-modulus prescaler value
) (
    input  wire logic              i_mclk,          // system clock 100 MHz
    input  wire logic              i_rst_n,         // synchronous reset, low active
    input  wire logic              i_sclk,          // serial clock pin
    input  wire logic              i_sdata,         // serial data pin
    input  wire logic              i_load_strobe,   // load strobe pin
    input  wire logic              i_ref_div_pulse, // reference divider output pulse
    input  wire logic              i_phase_ok,      // phase error under 15 ns this cycle
    input  wire logic [7:0]        i_mux_sources,   // internal signals for output mux
    output logic                   o_muxed_test_output, // multiplexed output pin
    output logic                   o_phase_polarity_bit, // detector polarity
    output logic                   o_counter_reset, // counters held in reset
    output logic [1:0]             o_core_power,    // core power code
    output logic [A_W-1:0]         o_a_count,       // A counter value
    output logic [B_W-1:0]         o_b_count,       // B counter value
    output logic [19:0]            o_feedback_ratio, // P*B+A
    output logic                   o_pump_gain_bit, // 1 current setting 2
    output logic                   o_output_halving_bit, // output divide-by-two
    output logic                   o_prescaler_source_bit, // halved output to prescaler
    output logic [R_W-1:0]         o_r_count,       // reference divide ratio
    output logic [1:0]             o_backlash_width, // antibacklash width code
    output logic                   o_locked,        // digital lock detect
    output logic                   o_band_clock     // band select clock enable pulse
);

    // refuse prescaler values outside 1 to 64, which keep P*B+A within 19 bits
    if (PRESCALER < 1 || PRESCALER > 64) begin : g_bad_prescaler
        $error("PRESCALER out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] sclk_s1_r;
    logic [2:0] sclk_s2_r;
    logic       sclk_d_r;
    logic       strobe_d_r;

    // two flops per pin, then a delayed copy for edges
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sclk_s1_r <= 3'h0;
            sclk_s2_r <= 3'h0;
            sclk_d_r  <= 1'b0;
            strobe_d_r <= 1'b0;
        end else begin
            sclk_s1_r <= {i_load_strobe, i_sdata, i_sclk};
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r  <= sclk_s2_r[0];
            strobe_d_r <= sclk_s2_r[2];
        end
    end

    wire sclk_rise = sclk_s2_r[0] & ~sclk_d_r;
    wire strobe_rise = sclk_s2_r[2] & ~strobe_d_r;
    wire data_bit  = sclk_s2_r[1];

    ////////////////////////////////////////////////////////////////////////
    // input shift register, msb first
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] shift_nxt;

    assign shift_nxt = {shift_r[WORD_W-2:0], data_bit};

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            shift_r <= 24'h000000;
        end else if (sclk_rise) begin
            shift_r <= shift_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latch decode on load strobe edge
    wire [1:0] sel      = shift_r[1:0];
    wire       load_ctl = strobe_rise && (sel == SEL_CONTROL);
    wire       load_n   = strobe_rise && (sel == SEL_FEEDBK);
    wire       load_r   = strobe_rise && (sel == SEL_REF);

    logic [WORD_W-1:0] ctl_r;
    logic [WORD_W-1:0] n_r;
    logic [WORD_W-1:0] r_r;
    logic              gain_r;

    // latches move only on the strobe edge
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ctl_r  <= CTL_RESET;
            n_r    <= N_RESET;
            r_r    <= R_RESET;
            gain_r <= 1'b0;
        end else begin
            if (load_ctl) begin
                ctl_r  <= shift_r;
                gain_r <= shift_r[CTL_PUMP_GAIN];
            end
            if (load_n) begin
                n_r    <= shift_r;
                gain_r <= shift_r[N_PUMP_GAIN];
            end
            if (load_r) begin
                r_r <= shift_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field decode
    wire [A_W-1:0] a_val  = n_r[N_A_LSB +: A_W];
    wire [B_W-1:0] b_val  = n_r[N_B_LSB +: B_W];
    wire [R_W-1:0] r_val  = r_r[R_COUNT_LSB +: R_W];
    wire [2:0]     outsel = ctl_r[CTL_OUTSEL_LSB +: 3];
    wire           test_on = r_r[R_TEST];
    wire [19:0]    ratio  = 20'(PRESCALER) * 20'(b_val) + 20'(a_val);
    wire [1:0]     band_div = r_r[R_BAND_DIV_LSB +: 2];
    // test bit set forces mux output low, otherwise output from normal select
    wire           mux_bit = test_on ? 1'b0 : i_mux_sources[outsel];

    ////////////////////////////////////////////////////////////////////////
    // lock detect on reference pulses
    logic [2:0] lock_cnt_r;
    wire  [2:0] lock_need = r_r[R_LOCK_PREC] ? LOCK_CNT_FINE : LOCK_CNT_COARSE;
    wire        cnt_reset = ctl_r[CTL_COUNTER_RESET];

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || cnt_reset) begin
            lock_cnt_r <= 3'h0;
        end else if (i_ref_div_pulse) begin
            if (!i_phase_ok) begin
                lock_cnt_r <= 3'h0;
            end else if (lock_cnt_r < lock_need) begin
                lock_cnt_r <= lock_cnt_r + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // band select clock divider: 1, 2, 4 or 8
    logic [2:0] band_cnt_r;
    wire  [2:0] band_top = 3'((4'h1 << band_div) - 4'h1);
    wire        band_hit = i_ref_div_pulse && (band_cnt_r >= band_top);

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || cnt_reset) begin
            band_cnt_r <= 3'h0;
        end else if (i_ref_div_pulse) begin
            band_cnt_r <= band_hit ? 3'h0 : band_cnt_r + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs, one short process each

    // selected internal signal onto the shared output pin
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_muxed_test_output <= 1'b0;
        end else begin
            o_muxed_test_output <= mux_bit;
        end
    end

    // detector polarity, 1 for passive filters
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_phase_polarity_bit <= 1'b0;
        end else begin
            o_phase_polarity_bit <= ctl_r[CTL_PHASE_POL];
        end
    end

    // counter reset hold, must be 0 in normal use
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_counter_reset <= 1'b0;
        end else begin
            o_counter_reset <= cnt_reset;
        end
    end

    // core power code as written by the host
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_core_power <= 2'h0;
        end else begin
            o_core_power <= ctl_r[CTL_CORE_POWER_LSB +: 2];
        end
    end

    // A counter value, full 0 to 31 range
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_a_count <= '0;
        end else begin
            o_a_count <= a_val;
        end
    end

    // B counter value, host keeps it at 3 or above
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_b_count <= '0;
        end else begin
            o_b_count <= b_val;
        end
    end

    // overall feedback ratio, moves together with A and B
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_feedback_ratio <= 20'h00000;
        end else begin
            o_feedback_ratio <= ratio;
        end
    end

    // shared pump gain, latest latch write wins
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_pump_gain_bit <= 1'b0;
        end else begin
            o_pump_gain_bit <= gain_r;
        end
    end

    // output divide-by-two enable
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_output_halving_bit <= 1'b0;
        end else begin
            o_output_halving_bit <= n_r[N_HALVING];
        end
    end

    // prescaler fed from halved or fundamental output
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_prescaler_source_bit <= 1'b0;
        end else begin
            o_prescaler_source_bit <= n_r[N_PRESC_SRC];
        end
    end

    // reference divide ratio
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_r_count <= '0;
        end else begin
            o_r_count <= r_val;
        end
    end

    // antibacklash pulse width code
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_backlash_width <= 2'h0;
        end else begin
            o_backlash_width <= r_r[R_BACKLASH_LSB +: 2];
        end
    end

    // lock flag, forced low while counters are held
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_locked <= 1'b0;
        end else begin
            o_locked <= (lock_cnt_r >= lock_need) && !cnt_reset;
        end
    end

    // band select clock pulse, one cycle after the reference pulse
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_band_clock <= 1'b0;
        end else begin
            o_band_clock <= band_hit && !cnt_reset;
        end
    end

endmodule

// file: testbench/pll_latch_chk.sv
// concurrent checks on the latch bank ports
`timescale 1ns/100ps
module latch_chk
    import pll_latch_pkg::*;
#(
    parameter int PRESCALER = 8              // dual-modulus prescaler value
) (
    input wire logic           i_mclk,                 // system clock
    input wire logic           i_rst_n,                // sync reset, low active
    input wire logic           i_load_strobe,          // load strobe pin
    input wire logic           i_ref_div_pulse,        // reference pulse
    input wire logic           i_phase_ok,             // phase error small
    input wire logic           o_phase_polarity_bit,   // polarity
    input wire logic           o_counter_reset,        // counters in reset
    input wire logic [1:0]     o_core_power,           // core power code
    input wire logic [A_W-1:0] o_a_count,              // A count
    input wire logic [B_W-1:0] o_b_count,              // B count
    input wire logic [19:0]    o_feedback_ratio,       // P*B+A
    input wire logic           o_pump_gain_bit,        // pump gain
    input wire logic           o_output_halving_bit,   // output halving
    input wire logic           o_prescaler_source_bit, // prescaler source
    input wire logic [R_W-1:0] o_r_count,              // reference ratio
    input wire logic [1:0]     o_backlash_width,       // backlash code
    input wire logic           o_locked,               // lock detect
    input wire logic           o_band_clock            // band clock pulse
);
    logic [3:0]  quiet_r;
    wire  [40:0] cfg_w;
    // latched fields except output select, lock precision, test bit and band divide in one bundle
    assign cfg_w = {o_r_count, o_backlash_width, o_a_count, o_b_count, o_phase_polarity_bit,
        o_core_power, o_pump_gain_bit, o_output_halving_bit, o_prescaler_source_bit,
        o_counter_reset};
    // cycles since the load strobe was last high, saturating
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || i_load_strobe) quiet_r <= 4'h0;
        else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    a_ratio_sum: assert property (
        $stable(o_a_count) && $stable(o_b_count) |->
        int'(o_feedback_ratio) == PRESCALER * int'(o_b_count) + int'(o_a_count))
        else $error("feedback ratio is not P*B+A");
    a_quiet_shift: assert property ($changed(cfg_w) |-> quiet_r < 4'h8)
        else $error("latch changed without load strobe");
    a_lock_reset: assert property (o_counter_reset [*3] |-> !o_locked)
        else $error("lock held under counter reset");
    a_lock_cause: assert property (
        $rose(o_locked) |-> $past(i_ref_div_pulse, 1) || $past(i_ref_div_pulse, 2)
        || $past(i_ref_div_pulse, 3))
        else $error("lock rose without reference pulse");
    a_lock_drop: assert property (i_ref_div_pulse && !i_phase_ok |-> ##[1:3] !o_locked)
        else $error("lock kept after bad phase cycle");
    a_lock_clean: assert property ($rose(o_locked) |-> !$past(o_counter_reset))
        else $error("lock rose while counters reset");
    a_band_after: assert property (o_band_clock |-> $past(i_ref_div_pulse))
        else $error("band clock not after reference pulse");
    a_band_single: assert property (o_band_clock |=> !o_band_clock)
        else $error("band clock wider than one cycle");
    c_lock: cover property ($rose(o_locked));
    c_band: cover property (o_band_clock);
    c_reset: cover property ($rose(o_counter_reset));
endmodule

bind pll_divider_latches latch_chk #(.PRESCALER(PRESCALER)) u_latch_chk (
    .i_mclk, .i_rst_n, .i_load_strobe, .i_ref_div_pulse, .i_phase_ok, .o_phase_polarity_bit,
    .o_counter_reset, .o_core_power, .o_a_count, .o_b_count, .o_feedback_ratio,
    .o_pump_gain_bit, .o_output_halving_bit, .o_prescaler_source_bit, .o_r_count,
    .o_backlash_width, .o_locked, .o_band_clock);

// file: testbench/serial_host.sv
// host model that shifts 24-bit words into the latch bank
`timescale 1ns/100ps
module serial_host (
    input  wire logic i_mclk,        // bench clock
    output logic      o_sclk,        // serial clock, still between words
    output logic      o_sdata,       // serial data
    output logic      o_load_strobe  // load strobe
);
    initial begin
        o_sclk = 1'b0;
        o_sdata = 1'b0;
        o_load_strobe = 1'b0;
    end
    // msb first, 80 ns serial clock, data steady four mclk around each rise
    task automatic send(input logic [23:0] w, input bit load);
        for (int i = 23; i >= 0; i--) begin
            o_sdata <= w[i];
            repeat (4) @(posedge i_mclk);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_mclk);
            o_sclk <= 1'b0;
        end
        o_sdata <= ~w[0]; // released line shows no stale bit
        if (load) begin
            o_load_strobe <= 1'b1;
            repeat (10) @(posedge i_mclk);
            o_load_strobe <= 1'b0;
        end
        repeat (4) @(posedge i_mclk);
    endtask
endmodule

// file: testbench/test_pll_divider_latches.sv
// self-checking bench for the serial divider latch bank
`timescale 1ns/100ps
module test_pll_divider_latches;
    import pll_latch_pkg::*;
    localparam int         PRESCALER = 8;
    localparam logic [1:0] CORE_15MA = 2'h1; // plain nonzero code, reset loads 0
    logic        i_mclk, i_rst_n, pulse_r, ok_r;
    logic [7:0]  mux_src;
    wire         sclk, sdata, strobe, mux_o, pol, crst, gain, halv, psrc, lock, band;
    wire  [1:0]  cpw, bw;
    wire  [4:0]  a;
    wire  [12:0] b;
    wire  [19:0] ratio;
    wire  [13:0] r;
    int          error_cnt = 0, tests_run = 0, band_n = 0;
    serial_host host (.i_mclk(i_mclk), .o_sclk(sclk), .o_sdata(sdata), .o_load_strobe(strobe));
    pll_divider_latches #(.PRESCALER(PRESCALER)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_sclk(sclk), .i_sdata(sdata), .i_load_strobe(strobe), .i_ref_div_pulse(pulse_r),
        .i_phase_ok(ok_r), .i_mux_sources(mux_src), .o_muxed_test_output(mux_o),
        .o_phase_polarity_bit(pol), .o_counter_reset(crst), .o_core_power(cpw),
        .o_a_count(a), .o_b_count(b), .o_feedback_ratio(ratio), .o_pump_gain_bit(gain),
        .o_output_halving_bit(halv), .o_prescaler_source_bit(psrc), .o_r_count(r),
        .o_backlash_width(bw), .o_locked(lock), .o_band_clock(band));
    task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", n, e, g);
        end
    endtask
    // reference pulses, each followed by three idle cycles
    task automatic pulse(input int n, input logic ok);
        repeat (n) begin
            @(posedge i_mclk);
            pulse_r <= 1'b1;
            ok_r <= ok;
            @(posedge i_mclk);
            pulse_r <= 1'b0;
            repeat (3) @(posedge i_mclk);
        end
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) if (band === 1'b1) band_n++;
    initial begin
        repeat (100000) @(posedge i_mclk);
        error_cnt++;
        end_of_test();
    end
    // programming order: reference, control, feedback
    initial begin
        i_rst_n = 1'b0;
        pulse_r = 1'b0;
        ok_r = 1'b0;
        mux_src = 8'h00;
        repeat (20) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_mclk);
        chk("reset", 20'h0, {r, a, lock});
        host.send({2'h0, 2'h2, 1'b0, 1'b1, 2'h2, 14'h3fff, SEL_REF}, 1);
        chk("r_count", 14'h3fff, r);
        chk("backlash", 2'h2, bw);
        for (int i = 0; i < 8; i++) begin
            mux_src <= 8'h01 << i;
            host.send({13'h0, 1'b1, 1'b0, 1'b1, 3'(i), 1'b0, CORE_15MA, SEL_CONTROL}, 1);
            chk("mux_hi", 1'b1, mux_o);
            mux_src <= ~(8'h01 << i);
            repeat (4) @(posedge i_mclk);
            chk("mux_lo", 1'b0, mux_o);
        end
        chk("polarity", 1'b1, pol);
        chk("core_power", CORE_15MA, cpw);
        chk("gain_ctl", 1'b1, gain);
        host.send({1'b1, 1'b1, 1'b0, 13'h0003, 1'b0, 5'h1f, SEL_FEEDBK}, 1);
        chk("a_count", 5'h1f, a);
        chk("b_count", 13'h0003, b);
        chk("ratio", PRESCALER * 3 + 31, ratio);
        chk("gain_n", 1'b0, gain);
        chk("halving", 1'b1, halv);
        chk("presc_src", 1'b1, psrc);
        host.send({22'h000001, 2'h3}, 1);
        host.send({22'h000001, SEL_REF}, 0);
        chk("r_kept", 14'h3fff, r);
        band_n = 0;
        pulse(4, 1'b1);
        chk("lock_four", 1'b0, lock);
        pulse(1, 1'b1);
        chk("lock_five", 1'b1, lock);
        pulse(1, 1'b0);
        chk("lock_lost", 1'b0, lock);
        pulse(2, 1'b0);
        chk("band_div4", 2, band_n);
        host.send({2'h0, 2'h0, 1'b0, 1'b0, 2'h1, 14'h0002, SEL_REF}, 1);
        band_n = 0;
        pulse(3, 1'b1);
        chk("lock_three", 1'b1, lock);
        chk("band_div1", 3, band_n);
        host.send({13'h0, 1'b0, 1'b0, 1'b1, 3'h0, 1'b1, CORE_15MA, SEL_CONTROL}, 1);
        chk("cnt_reset", 1'b1, crst);
        chk("lock_rst", 1'b0, lock);
        chk("gain_last", 1'b0, gain);
        end_of_test();
    end
endmodule
